/* File: rtl/ppdc_pkg.sv */
// Package: constants and types of the timing port drop counter and transmit parse block
package ppdc_pkg;

    // Register offsets (byte addresses)
    localparam int          ADDR_W         = 9;
    localparam logic [8:0]  OFF_TX_PARSE   = 9'h158;
    localparam logic [8:0]  OFF_CKS_DROPS  = 9'h188;
    localparam logic [8:0]  OFF_FLT_DROPS  = 9'h18c;
    localparam logic [8:0]  OFF_BANK_SEL   = 9'h1f0;
    localparam logic [8:0]  OFF_IRQ_STAT   = 9'h1f4;
    localparam logic [8:0]  OFF_IRQ_MASK   = 9'h1f8;

    // Banks
    localparam logic [2:0]  BANK_COUNTERS  = 3'h1;
    localparam logic [2:0]  BANK_PARSE     = 3'h2;
    localparam logic [2:0]  BANK_RST       = 3'h0;

    // Transmit parse enable field: bits 14..11
    localparam int          CFG_LSB        = 11;
    localparam int          CFG_W          = 4;
    localparam logic [3:0]  CFG_RST        = 4'he;
    localparam int          CFG_L2_A       = 3;
    localparam int          CFG_L2_B       = 2;
    localparam int          CFG_IP_A       = 1;
    localparam int          CFG_IP_B       = 0;

    // Counters
    localparam logic [31:0] CNT_MAX        = 32'hffff_ffff;
    localparam logic [31:0] CNT_RST        = 32'h0000_0000;

    // Interrupt status bit positions
    localparam int          IRQ_W          = 5;
    localparam int          IRQ_CKS_DROP   = 0;
    localparam int          IRQ_FLT_DROP   = 1;
    localparam int          IRQ_CKS_SAT    = 2;
    localparam int          IRQ_FLT_SAT    = 3;
    localparam int          IRQ_CFG_LIVE   = 4;

    // Timing destination addresses
    localparam logic [47:0] MAC_L2_A       = 48'h0180_c200_000e;
    localparam logic [47:0] MAC_L2_B       = 48'h011b_1900_0000;
    localparam logic [47:0] MAC_V4_A       = 48'h0100_5e00_0181;
    localparam logic [47:0] MAC_V4_B       = 48'h0100_5e00_0182;
    localparam logic [47:0] MAC_V6_A       = 48'h3333_0000_0181;
    localparam logic [47:0] MAC_V6_B       = 48'h3333_0000_0182;
    localparam logic [31:0] IP4_A          = 32'he000_0181;
    localparam logic [31:0] IP4_B          = 32'he000_0182;
    localparam logic [7:0]  IP6_TOP        = 8'hff;
    localparam logic [115:0] IP6_LOW_A     = 116'h181;
    localparam logic [115:0] IP6_LOW_B     = 116'h182;

    // Outgoing frame kinds
    typedef enum logic [1:0] {PPDC_L2, PPDC_IPV4, PPDC_IPV6, PPDC_OTHER} ppdc_kind_t;

    // Outgoing frame header as seen by the parser
    typedef struct packed {
        logic         valid;
        ppdc_kind_t   kind;
        logic [47:0]  dest_mac;
        logic [127:0] dest_ip;
    } ppdc_tx_hdr_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0]      checksum_drop_tally;
        logic [31:0]      filter_drop_tally;
        logic [CFG_W-1:0] tx_cfg;
        logic [2:0]       bank;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]      rd_data;
        logic             frame_err;
        logic             tx_valid;
        logic             tx_match;
    } ppdc_state_t;

endpackage

/* File: rtl/ppdc_top.sv */
// Module: timing port drop counters and transmit parse configuration
//
// Function
// - Count each ingress packet dropped for bad UDP checksum in 32 bits.
// - Every checksum or filter drop is also flagged as an errored frame.
// - Count each ingress packet removed by message filtering in 32 bits.
// - Writing zero to a drop counter clears it.
// - Drop counters stop at all ones and never wrap.
// - Bit 14, reset one, accepts layer 2 destination 01:80:C2:00:00:0E.
// - Bit 13, reset one, accepts layer 2 destination 01:1B:19:00:00:00.
// - Bit 12, reset one, accepts IPv4 to 224.0.1.129 via its multicast MAC.
// - Bit 12 also accepts IPv6 to FFX0::181 via MAC 33:33:00:00:01:81.
// - Bit 11, reset zero, accepts IPv4 to 224.0.1.130 via its multicast MAC.
// - Bit 11 also accepts IPv6 to FFX0::182 via MAC 33:33:00:00:01:82.
// - Bank select picks the responding set; parse register in bank 2.
`timescale 1ns/1ns
`default_nettype none

module ppdc_top
    import ppdc_pkg::*;
(
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wr_data,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rd_data,
    // Receive path events
    input  wire logic              i_rx_cks_drop,
    input  wire logic              i_rx_flt_drop,
    output logic                   o_rx_frame_error,
    // Transmit parser
    input  wire ppdc_tx_hdr_t      i_tx_hdr,
    output logic                   o_tx_valid,
    output logic                   o_tx_ts_match,
    // Global time stamping enable
    input  wire logic              i_ts_enable,
    // Interrupt
    output logic                   o_irq
);

    ////////////////////////////////////////////////////////////////////////////

    ppdc_state_t s;
    ppdc_state_t next_s;

    logic             hit_parse;
    logic             hit_cks;
    logic             hit_flt;
    logic             clr_cks;
    logic             clr_flt;
    logic             cks_sat;
    logic             flt_sat;
    logic [IRQ_W-1:0] events;
    logic             mac_a;
    logic             mac_b;
    logic             v4_a;
    logic             v4_b;
    logic             v6_a;
    logic             v6_b;
    logic             ip6_top;

    ////////////////////////////////////////////////////////////////////////////

    // Banked decode
    assign hit_parse = (i_addr == OFF_TX_PARSE) && (s.bank == BANK_PARSE);
    assign hit_cks   = (i_addr == OFF_CKS_DROPS) && (s.bank == BANK_COUNTERS);
    assign hit_flt   = (i_addr == OFF_FLT_DROPS) && (s.bank == BANK_COUNTERS);

    // Clear by writing zero
    assign clr_cks = i_wr && hit_cks && (i_wr_data == CNT_RST);
    assign clr_flt = i_wr && hit_flt && (i_wr_data == CNT_RST);

    assign cks_sat = (s.checksum_drop_tally == CNT_MAX);
    assign flt_sat = (s.filter_drop_tally == CNT_MAX);

    // Destination matches
    assign mac_a   = (i_tx_hdr.dest_mac == MAC_L2_A);
    assign mac_b   = (i_tx_hdr.dest_mac == MAC_L2_B);
    assign v4_a    = (i_tx_hdr.dest_mac == MAC_V4_A) && (i_tx_hdr.dest_ip[31:0] == IP4_A);
    assign v4_b    = (i_tx_hdr.dest_mac == MAC_V4_B) && (i_tx_hdr.dest_ip[31:0] == IP4_B);
    assign ip6_top = (i_tx_hdr.dest_ip[127:120] == IP6_TOP);
    assign v6_a    = (i_tx_hdr.dest_mac == MAC_V6_A) && ip6_top
                     && (i_tx_hdr.dest_ip[115:0] == IP6_LOW_A);
    assign v6_b    = (i_tx_hdr.dest_mac == MAC_V6_B) && ip6_top
                     && (i_tx_hdr.dest_ip[115:0] == IP6_LOW_B);

    // Interrupt events
    always_comb begin
        events               = '0;
        events[IRQ_CKS_DROP] = i_rx_cks_drop;
        events[IRQ_FLT_DROP] = i_rx_flt_drop;
        events[IRQ_CKS_SAT]  = i_rx_cks_drop && !clr_cks
                               && (s.checksum_drop_tally == CNT_MAX - 32'h1);
        events[IRQ_FLT_SAT]  = i_rx_flt_drop && !clr_flt
                               && (s.filter_drop_tally == CNT_MAX - 32'h1);
        events[IRQ_CFG_LIVE] = i_wr && hit_parse && i_ts_enable;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;

        // Checksum drop tally
        if (clr_cks) begin
            next_s.checksum_drop_tally = CNT_RST;
        end else if (i_rx_cks_drop && !cks_sat) begin
            next_s.checksum_drop_tally = s.checksum_drop_tally + 32'h1;
        end

        // Filter drop tally
        if (clr_flt) begin
            next_s.filter_drop_tally = CNT_RST;
        end else if (i_rx_flt_drop && !flt_sat) begin
            next_s.filter_drop_tally = s.filter_drop_tally + 32'h1;
        end

        // Errored frame report
        next_s.frame_err = i_rx_cks_drop || i_rx_flt_drop;

        // Register writes
        if (i_wr) begin
            if (hit_parse) begin
                next_s.tx_cfg = i_wr_data[CFG_LSB +: CFG_W];
            end
            if (i_addr == OFF_BANK_SEL) begin
                next_s.bank = i_wr_data[2:0];
            end
            if (i_addr == OFF_IRQ_MASK) begin
                next_s.irq_mask = i_wr_data[IRQ_W-1:0];
            end
        end

        // Sticky status, set wins over write-one clear
        if (i_wr && (i_addr == OFF_IRQ_STAT)) begin
            next_s.irq_stat = (s.irq_stat & ~i_wr_data[IRQ_W-1:0]) | events;
        end else begin
            next_s.irq_stat = s.irq_stat | events;
        end

        // Read data, valid the cycle after the strobe
        next_s.rd_data = '0;
        if (i_rd) begin
            if (hit_parse) begin
                next_s.rd_data[CFG_LSB +: CFG_W] = s.tx_cfg;
            end else if (hit_cks) begin
                next_s.rd_data = s.checksum_drop_tally;
            end else if (hit_flt) begin
                next_s.rd_data = s.filter_drop_tally;
            end else if (i_addr == OFF_BANK_SEL) begin
                next_s.rd_data[2:0] = s.bank;
            end else if (i_addr == OFF_IRQ_STAT) begin
                next_s.rd_data[IRQ_W-1:0] = s.irq_stat;
            end else if (i_addr == OFF_IRQ_MASK) begin
                next_s.rd_data[IRQ_W-1:0] = s.irq_mask;
            end
        end

        // Transmit timing message detection
        next_s.tx_valid = i_tx_hdr.valid;
        next_s.tx_match = 1'b0;
        if (i_tx_hdr.valid) begin
            unique case (i_tx_hdr.kind)
                PPDC_L2: begin
                    next_s.tx_match = (s.tx_cfg[CFG_L2_A] && mac_a)
                                   || (s.tx_cfg[CFG_L2_B] && mac_b);
                end
                PPDC_IPV4: begin
                    next_s.tx_match = (s.tx_cfg[CFG_IP_A] && v4_a)
                                   || (s.tx_cfg[CFG_IP_B] && v4_b);
                end
                PPDC_IPV6: begin
                    next_s.tx_match = (s.tx_cfg[CFG_IP_A] && v6_a)
                                   || (s.tx_cfg[CFG_IP_B] && v6_b);
                end
                PPDC_OTHER: begin
                    next_s.tx_match = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s                     <= '0;
            s.checksum_drop_tally <= CNT_RST;
            s.filter_drop_tally   <= CNT_RST;
            s.tx_cfg              <= CFG_RST;
            s.bank                <= BANK_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Outputs
    assign o_rd_data        = s.rd_data;
    assign o_rx_frame_error = s.frame_err;
    assign o_tx_valid       = s.tx_valid;
    assign o_tx_ts_match    = s.tx_match;
    assign o_irq            = |(s.irq_stat & s.irq_mask);

    ////////////////////////////////////////////////////////////////////////////

    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    AST_CKS_COUNT: assert property (
        (i_rx_cks_drop && !clr_cks && !cks_sat)
        |=> (s.checksum_drop_tally == $past(s.checksum_drop_tally) + 32'h1))
        else $error("Checksum drop tally did not advance by one");

    AST_FRAME_ERR: assert property (
        (i_rx_cks_drop || i_rx_flt_drop) |=> o_rx_frame_error)
        else $error("Dropped packet not reported as errored frame");

    AST_FLT_COUNT: assert property (
        (i_rx_flt_drop && !clr_flt && !flt_sat)
        |=> (s.filter_drop_tally == $past(s.filter_drop_tally) + 32'h1))
        else $error("Filter drop tally did not advance by one");

    AST_FLT_HOLD: assert property (
        (!i_rx_flt_drop && !clr_flt) |=> $stable(s.filter_drop_tally))
        else $error("Filter drop tally moved without a drop");

    AST_CLEAR: assert property (
        (i_wr && i_addr == OFF_FLT_DROPS && s.bank == BANK_COUNTERS && i_wr_data == CNT_RST)
        ##1 (i_rd && i_addr == OFF_FLT_DROPS && !i_rx_flt_drop) |=> (o_rd_data == CNT_RST))
        else $error("Filter drop tally not cleared by a zero write");

    AST_SAT: assert property (
        (cks_sat && !clr_cks) |=> (s.checksum_drop_tally == CNT_MAX))
        else $error("Checksum drop tally left saturation");

    AST_L2_A: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_L2 && mac_a && s.tx_cfg[CFG_L2_A])
        |=> (o_tx_valid && o_tx_ts_match))
        else $error("Layer 2 destination A not accepted");

    AST_L2_B: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_L2 && !mac_a && mac_b
         && !s.tx_cfg[CFG_L2_B]) |=> !o_tx_ts_match)
        else $error("Layer 2 destination B accepted while disabled");

    AST_V4_A: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV4 && v4_a && s.tx_cfg[CFG_IP_A])
        |=> o_tx_ts_match)
        else $error("IPv4 destination A not accepted");

    AST_V6_A: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV6 && v6_a && s.tx_cfg[CFG_IP_A])
        |=> o_tx_ts_match)
        else $error("IPv6 destination A not accepted");

    AST_V4_B: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV4 && v4_b && !s.tx_cfg[CFG_IP_B])
        |=> !o_tx_ts_match)
        else $error("IPv4 destination B accepted while disabled");

    AST_V6_B: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV6 && v6_b && s.tx_cfg[CFG_IP_B])
        |=> o_tx_ts_match)
        else $error("IPv6 destination B not accepted");

    AST_BANK: assert property (
        (i_rd && i_addr == OFF_TX_PARSE && s.bank != BANK_PARSE) |=> (o_rd_data == '0))
        else $error("Parse register answered outside its bank");

    AST_CLR_WINS: assert property (
        (clr_cks && i_rx_cks_drop) |=> (s.checksum_drop_tally == CNT_RST))
        else $error("Drop overrode a same cycle software clear");

    AST_CKS_HOLD: assert property (
        (!i_rx_cks_drop && !clr_cks) |=> $stable(s.checksum_drop_tally))
        else $error("Checksum drop tally moved without a drop");

    AST_FRAME_IDLE: assert property (
        (!i_rx_cks_drop && !i_rx_flt_drop) |=> !o_rx_frame_error)
        else $error("Errored frame reported without a drop");

    AST_CKS_CLR: assert property (
        clr_cks |=> (s.checksum_drop_tally == CNT_RST))
        else $error("Checksum drop tally not cleared by a zero write");

    AST_NZ_WRITE: assert property (
        (i_wr && hit_cks && i_wr_data != CNT_RST && !i_rx_cks_drop)
        |=> $stable(s.checksum_drop_tally))
        else $error("Non-zero write changed the checksum drop tally");

    AST_FLT_SAT: assert property (
        (flt_sat && !clr_flt) |=> (s.filter_drop_tally == CNT_MAX))
        else $error("Filter drop tally left saturation");

    AST_NO_VALID: assert property (
        !i_tx_hdr.valid |=> (!o_tx_valid && !o_tx_ts_match))
        else $error("Match reported without a valid header");

    AST_OTHER_KIND: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_OTHER) |=> !o_tx_ts_match)
        else $error("Unlisted frame kind accepted");

    AST_L2_B_ON: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_L2 && mac_b && s.tx_cfg[CFG_L2_B])
        |=> o_tx_ts_match)
        else $error("Layer 2 destination B not accepted");

    AST_V6_A_OFF: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV6 && v6_a && !s.tx_cfg[CFG_IP_A])
        |=> !o_tx_ts_match)
        else $error("IPv6 destination A accepted while disabled");

    AST_V4_B_ON: assert property (
        (i_tx_hdr.valid && i_tx_hdr.kind == PPDC_IPV4 && v4_b && s.tx_cfg[CFG_IP_B])
        |=> o_tx_ts_match)
        else $error("IPv4 destination B not accepted");

    AST_CFG_LIVE: assert property (
        (i_wr && hit_parse && i_ts_enable) |=> s.irq_stat[IRQ_CFG_LIVE])
        else $error("Parse write during time stamping not flagged");

    AST_PARSE_WR: assert property (
        (i_wr && i_addr == OFF_TX_PARSE && s.bank != BANK_PARSE) |=> $stable(s.tx_cfg))
        else $error("Parse register written outside its bank");

    AST_FLT_CLR_WINS: assert property (
        (clr_flt && i_rx_flt_drop) |=> (s.filter_drop_tally == CNT_RST))
        else $error("Drop overrode a same cycle filter tally clear");

    COV_CKS_SAT: cover property (i_rx_cks_drop ##1 cks_sat);
    COV_CLR_DROP: cover property (clr_flt && i_rx_flt_drop);
    COV_V6_MATCH: cover property (o_tx_ts_match && $past(i_tx_hdr.kind) == PPDC_IPV6);
    COV_IRQ: cover property ($rose(o_irq));

endmodule

`default_nettype wire

/* File: tb/ppdc_net_model.sv */
// Traffic path model: ingress drop pulses and outgoing frame headers
`timescale 1ns/1ns
`default_nettype none

module ppdc_net_model
    import ppdc_pkg::*;
(
    // Clock
    input  wire logic          i_core_clk,
    // Requests from the bench
    input  wire logic          i_cks,
    input  wire logic          i_flt,
    input  wire ppdc_tx_hdr_t  i_hdr,
    // Toward the block
    output logic               o_cks_drop,
    output logic               o_flt_drop,
    output ppdc_tx_hdr_t       o_hdr
);
    ppdc_tx_hdr_t last = '0;

    ////////////////////////////////////////////////////////////////////////
    // Destination MAC and IP outside a valid cycle change every cycle
    always @(posedge i_core_clk) begin
        last <= o_hdr;
    end

    always_comb begin
        o_cks_drop = i_cks;
        o_flt_drop = i_flt;
        o_hdr      = i_hdr;
        if (!i_hdr.valid) begin
            o_hdr.dest_mac = ~last.dest_mac;
            o_hdr.dest_ip  = ~last.dest_ip;
        end
    end
endmodule
`default_nettype wire

/* File: tb/ppdc_top_tb_top.sv */
// Self-checking bench of the drop counters and transmit parse block
`timescale 1ns/1ns
`default_nettype none

module ppdc_top_tb_top
    import ppdc_pkg::*;
;
    logic         i_core_clk  = 1'b0;
    logic         i_rst       = 1'b1;
    logic [8:0]   i_addr      = '0;
    logic [31:0]  i_wr_data   = '0;
    logic         i_wr        = 1'b0;
    logic         i_rd        = 1'b0;
    logic         i_ts_enable = 1'b0;
    logic         cks         = 1'b0;
    logic         flt         = 1'b0;
    ppdc_tx_hdr_t hdr         = '0;
    ppdc_tx_hdr_t m_hdr, h;
    logic         m_cks, m_flt, o_irq, o_tx_valid, o_tx_ts_match, o_rx_frame_error;
    logic [31:0]  o_rd_data;
    logic [31:0]  seed        = 32'hd13bb7f6;
    logic [31:0]  rq[$];
    logic         tq[$], fq[$];
    logic         rd_d        = 1'b0;
    logic [3:0]   cfg_m       = 4'he;
    int           n_errors    = 0;
    int           n_compared  = 0;
    int           nc, nf;
    ppdc_kind_t   kd[8] = '{PPDC_L2, PPDC_L2, PPDC_IPV4, PPDC_IPV4, PPDC_IPV6, PPDC_IPV6, PPDC_IPV4, PPDC_OTHER};
    logic [47:0]  mc[8] = '{MAC_L2_A, MAC_L2_B, MAC_V4_A, MAC_V4_B, MAC_V6_A, MAC_V6_B, MAC_V4_A, MAC_L2_A};
    logic [127:0] ip[8] = '{128'h0, 128'h0, {96'h0, IP4_A}, {96'h0, IP4_B}, {IP6_TOP, 4'h0, IP6_LOW_A},
                            {IP6_TOP, 4'h0, IP6_LOW_B}, {96'h0, IP4_B}, 128'h0};

    ppdc_top u_dut (
        .i_core_clk       (i_core_clk),
        .i_rst            (i_rst),
        .i_addr           (i_addr),
        .i_wr_data        (i_wr_data),
        .i_wr             (i_wr),
        .i_rd             (i_rd),
        .o_rd_data        (o_rd_data),
        .i_rx_cks_drop    (m_cks),
        .i_rx_flt_drop    (m_flt),
        .o_rx_frame_error (o_rx_frame_error),
        .i_tx_hdr         (m_hdr),
        .o_tx_valid       (o_tx_valid),
        .o_tx_ts_match    (o_tx_ts_match),
        .i_ts_enable      (i_ts_enable),
        .o_irq            (o_irq)
    );

    ppdc_net_model u_net (
        .i_core_clk (i_core_clk),
        .i_cks      (cks),
        .i_flt      (flt),
        .i_hdr      (hdr),
        .o_cks_drop (m_cks),
        .o_flt_drop (m_flt),
        .o_hdr      (m_hdr)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial forever #50 i_core_clk = ~i_core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic exp_match(input ppdc_tx_hdr_t x);
        logic a6, b6;
        a6 = x.dest_ip[127:120] == 8'hff && x.dest_ip[115:0] == 116'h181;
        b6 = x.dest_ip[127:120] == 8'hff && x.dest_ip[115:0] == 116'h182;
        case (x.kind)
            PPDC_L2:   return (cfg_m[3] && x.dest_mac == MAC_L2_A) || (cfg_m[2] && x.dest_mac == MAC_L2_B);
            PPDC_IPV4: return (cfg_m[1] && x.dest_mac == MAC_V4_A && x.dest_ip[31:0] == 32'he000_0181)
                           || (cfg_m[0] && x.dest_mac == MAC_V4_B && x.dest_ip[31:0] == 32'he000_0182);
            PPDC_IPV6: return (cfg_m[1] && x.dest_mac == MAC_V6_A && a6) || (cfg_m[0] && x.dest_mac == MAC_V6_B && b6);
            default:   return 1'b0;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle; every strobe is written once per edge
    task automatic step(input logic w, r, c, f, input logic [8:0] a, input logic [31:0] d, input ppdc_tx_hdr_t x);
        @(posedge i_core_clk);
        i_wr <= w;
        i_rd <= r;
        cks <= c;
        flt <= f;
        i_addr <= a;
        i_wr_data <= d;
        hdr <= x;
        if (r) rq.push_back(d);
        if (c | f) fq.push_back(1'b1);
        if (x.valid) tq.push_back(exp_match(x));
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        step(1'b1, 1'b0, 1'b0, 1'b0, a, d, '0);
    endtask

    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        step(1'b0, 1'b1, 1'b0, 1'b0, a, e, '0);
    endtask

    task automatic irq_chk(input logic [8:0] a, input logic [31:0] d, input logic e);
        wr(a, d);
        step(1'b0, 1'b0, 1'b0, 1'b0, '0, '0, '0);
        @(negedge i_core_clk);
        chk("irq", 32'(e), 32'(o_irq));
    endtask

    task automatic stop_test;
        chk("pending", 32'h0, 32'(rq.size() + tq.size() + fq.size()));
        $display("Compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: oldest note against each result that appears
    always @(posedge i_core_clk) begin
        if (!i_rst) begin
            chk("rd_data", rd_d ? rq.pop_front() : 32'h0, o_rd_data);
            if (o_tx_valid !== 1'b0)
                chk("ts_match", tq.size() ? 32'(tq.pop_front()) : 32'h2, 32'(o_tx_ts_match));
            if (o_rx_frame_error !== 1'b0)
                chk("frame_err", fq.size() ? 32'(fq.pop_front()) : 32'h2, 32'(o_rx_frame_error));
        end
        rd_d = i_rd;
    end

    initial begin
        #(100 * 5000);
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        wr(OFF_BANK_SEL, 32'h2);
        rd(OFF_CKS_DROPS, 32'h0);
        for (int j = 0; j < 4; j++) begin
            if (j > 0) begin
                seed = lfsr(seed);
                cfg_m = (j == 1) ? 4'h1 : seed[3:0];
                wr(OFF_TX_PARSE, 32'(cfg_m) << 11);
            end
            rd(OFF_TX_PARSE, 32'(cfg_m) << 11);
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                h = '{1'b1, kd[i], mc[i], ip[i]};
                if (kd[i] == PPDC_IPV6) h.dest_ip[119:116] = seed[3:0];
                step(1'b0, 1'b0, 1'b0, 1'b0, '0, '0, h);
            end
        end
        wr(OFF_BANK_SEL, 32'h1);
        wr(OFF_TX_PARSE, 32'h0);
        rd(OFF_TX_PARSE, 32'h0);
        nc = 0;
        nf = 0;
        repeat (40) begin
            seed = lfsr(seed);
            nc += seed[0];
            nf += seed[1];
            step(1'b0, 1'b0, seed[0], seed[1], '0, '0, '0);
        end
        rd(OFF_CKS_DROPS, 32'(nc));
        rd(OFF_FLT_DROPS, 32'(nf));
        wr(OFF_CKS_DROPS, seed | 32'h1);
        rd(OFF_CKS_DROPS, 32'(nc));
        step(1'b1, 1'b0, 1'b1, 1'b0, OFF_CKS_DROPS, '0, '0);
        rd(OFF_CKS_DROPS, 32'h0);
        wr(OFF_FLT_DROPS, 32'h0);
        rd(OFF_FLT_DROPS, 32'h0);
        rd(9'h100, 32'h0);
        rd(OFF_IRQ_STAT, {30'h0, nf != 0, 1'b1});
        irq_chk(OFF_IRQ_MASK, 32'h0, 1'b0);
        irq_chk(OFF_IRQ_MASK, 32'h1f, 1'b1);
        irq_chk(OFF_IRQ_STAT, 32'h1f, 1'b0);
        wr(OFF_BANK_SEL, 32'h2);
        rd(OFF_TX_PARSE, 32'(cfg_m) << 11);
        i_ts_enable <= 1'b1;
        irq_chk(OFF_TX_PARSE, 32'(cfg_m) << 11, 1'b1);
        @(posedge i_core_clk);
        i_ts_enable <= 1'b0;
        rd(OFF_IRQ_STAT, 32'h10);
        repeat (4) step(1'b0, 1'b0, 1'b0, 1'b0, '0, '0, '0);
        stop_test();
    end
endmodule
`default_nettype wire
